/* logic/scr_pkg.sv */
// Purpose: Shared constants and types for the sensor control register bank.
// Assumes: 16-bit direct-space words addressed by their printed byte offsets.
// Notes: Both ends of the register link import this package.
package scr_pkg;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] SCR_OFS_CTRL = 8'h32;
  localparam logic [7:0] SCR_OFS_THR = 8'h36;
  localparam logic [7:0] SCR_OFS_CHAN = 8'h38;
  localparam logic [7:0] SCR_OFS_FILT = 8'h3a;
  localparam logic [7:0] SCR_OFS_RSVD = 8'h3c;
  localparam logic [7:0] SCR_OFS_KEY = 8'h3e;
  localparam logic [7:0] SCR_OFS_ID0 = 8'h00;
  localparam logic [7:0] SCR_OFS_ID1 = 8'h01;
  // Host command port offsets.
  localparam logic [3:0] SCR_HOFS_ADDR = 4'h0;
  localparam logic [3:0] SCR_HOFS_WDATA = 4'h1;
  localparam logic [3:0] SCR_HOFS_CMD = 4'h2;
  localparam logic [3:0] SCR_HOFS_RDATA = 4'h3;
  localparam logic [3:0] SCR_HOFS_STAT = 4'h4;
  // ==========================================================================
  // Field positions and masks
  localparam int SCR_B_START = 12;
  localparam int SCR_B_IFLAG = 11;
  localparam int SCR_B_READY = 10;
  localparam logic [15:0] SCR_MSK_CTRL = 16'h007e;
  localparam logic [15:0] SCR_MSK_THR = 16'h0fff;
  localparam logic [15:0] SCR_MSK_CHAN = 16'h3f7f;
  localparam logic [15:0] SCR_MSK_FILT = 16'h077f;
  localparam int SCR_B_SIGN = 2;
  localparam int SCR_B_LATCH = 1;
  localparam int SCR_B_PPOL = 0;
  localparam logic [2:0] SCR_PM_LP3 = 3'h3;
  localparam logic [2:0] SCR_PM_LP4 = 3'h4;
  localparam logic [15:0] SCR_RST_ZERO = 16'h0000;
  // ==========================================================================
  // Identity rows; the values are arbitrary.
  localparam logic [3:0] SCR_FACTORY_TAG = 4'h5;
  localparam logic [7:0] SCR_DIE_Y_POSITION = 8'h2a;
  localparam logic [15:0] SCR_UNLOCK_VALUE = 16'ha5c3;
  localparam int SCR_CONV_CYCLES = 8;
  typedef enum logic [1:0] {
    SCR_H_IDLE = 2'b00,
    SCR_H_WR = 2'b01,
    SCR_H_RD = 2'b10,
    SCR_H_WAIT = 2'b11
  } scr_hstate_t;
endpackage

/* logic/scr_link_if.sv */
// Purpose: Register link between host and sensor control register bank.
// Assumes: One clock; read data valid the cycle after the read strobe.
// Notes: Multifunction pin carried as level plus enable.
`timescale 1ns/100ps
`default_nettype none
interface scr_link_if;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [31:0] row_data;
  logic ecc_single;
  logic ecc_multi;
  logic pin_drv;
  logic pin_oe;
  logic pin_host;
  modport device (input addr, wdata, wr, rd, pin_host,
    output rdata, row_data, ecc_single, ecc_multi, pin_drv, pin_oe);
  modport host (output addr, wdata, wr, rd, pin_host,
    input rdata, row_data, ecc_single, ecc_multi, pin_drv, pin_oe);
endinterface
`default_nettype wire

/* logic/scr_device.sv */
// Purpose: Device end of the sensor control register bank.
// Assumes: Host keeps reserved register zero and clears flags by writing zero.
// Notes: Conversion engine is a short counter standing in for the sensor.
// Notes on behaviour
// - Start bit launches conversion when ready clear
// - Standby until start bit or pin active
// - Interrupt flag latches; host writes zero clears
// - Ready flag latches after conversion; host clears
// - Sleep interval field steers duty cycle
// - Power mode field selects power configuration
// - Twelve-bit threshold split high and low
// - Channel off bits disable each channel
// - Invert bits flip each channel polarity
// - Source field picks compared signal
// - Sign bit picks below or above
// - Latch bit holds pin after condition clears
// - Polarity bit sets pin active level
// - Low-power bandwidth used in modes three, four
// - Active bandwidth used in modes zero to two
// - Angle direction bit sets code slope
// - Plane select picks angle axis pair
// - Host keeps reserved register at zero
// - Host writes key; device grants access
// - Rows report single and multi-bit errors
// - Identity rows hold tag and die position
`timescale 1ns/100ps
`default_nettype none
module scr_device
  import scr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Register link
  scr_link_if.device lnk,
  // Sensor side
  input wire logic [11:0] sense_value [16],
  input wire logic row_sel,
  input wire logic [1:0] row_ecc_err,
  output logic [2:0] chan_off,
  output logic [2:0] chan_invert,
  output logic [2:0] bandwidth_sel,
  output logic [2:0] sleep_interval,
  output logic [2:0] power_mode,
  output logic [3:0] angle_cfg,
  output logic memory_unlocked,
  output logic converting
);
  import scr_pkg::*;
  // ==========================================================================
  // Register state
  logic [15:0] ctrl_r, ctrl_nxt, thr_r, thr_nxt, chan_r, chan_nxt;
  logic [15:0] filt_r, filt_nxt, rsvd_r, rsvd_nxt, key_r, key_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic busy_r, busy_nxt, iflag_r, iflag_nxt, ready_r, ready_nxt;
  logic pin_act_r, pin_act_nxt, held_r, held_nxt;
  logic drv_r, drv_nxt, unl_r, unl_nxt;
  logic [2:0] bw_r, bw_nxt;
  logic [2:0] ps_r;
  logic [31:0] row_r, row_nxt;
  logic [1:0] ecc_r, ecc_nxt;
  logic cond, pin_req, wr_ctrl;
  logic [11:0] sig;

  function automatic logic [15:0] merge(input logic [15:0] d, input logic [15:0] m);
    merge = d & m;
  endfunction

  // Pin input synchroniser: first stage feeds only the second.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      // Reset to the idle level of an active-low pin, so no false start follows reset.
      ps_r <= 3'h7;
    end else begin
      ps_r <= {ps_r[1:0], lnk.pin_host};
    end
  end

  always_comb begin
    wr_ctrl = lnk.wr && (lnk.addr == SCR_OFS_CTRL);
    sig = sense_value[chan_r[6:3]];
    cond = chan_r[SCR_B_SIGN] ? (sig > thr_r[11:0]) : (sig < thr_r[11:0]);
    // Pin counts as active only when second and third stages agree.
    pin_req = (ps_r[1] == ps_r[2]) && (ps_r[2] == chan_r[SCR_B_PPOL]) && !busy_r;
    ctrl_nxt = ctrl_r;
    thr_nxt = thr_r;
    chan_nxt = chan_r;
    filt_nxt = filt_r;
    rsvd_nxt = rsvd_r;
    key_nxt = key_r;
    busy_nxt = busy_r;
    cnt_nxt = cnt_r;
    iflag_nxt = iflag_r;
    ready_nxt = ready_r;
    if (lnk.wr) begin
      unique case (lnk.addr)
        SCR_OFS_CTRL: ctrl_nxt = merge(lnk.wdata, SCR_MSK_CTRL);
        SCR_OFS_THR: thr_nxt = merge(lnk.wdata, SCR_MSK_THR);
        SCR_OFS_CHAN: chan_nxt = merge(lnk.wdata, SCR_MSK_CHAN);
        SCR_OFS_FILT: filt_nxt = merge(lnk.wdata, SCR_MSK_FILT);
        SCR_OFS_RSVD: rsvd_nxt = lnk.wdata;
        SCR_OFS_KEY: key_nxt = lnk.wdata;
        default: ;
      endcase
    end
    // Writes of zero clear the flags; a same-cycle event still sets them.
    if (wr_ctrl && !lnk.wdata[SCR_B_IFLAG]) begin
      iflag_nxt = 1'b0;
    end
    if (wr_ctrl && !lnk.wdata[SCR_B_READY]) begin
      ready_nxt = 1'b0;
    end
    if (!busy_r && ((wr_ctrl && lnk.wdata[SCR_B_START] && !ready_r) || pin_req)) begin
      busy_nxt = 1'b1;
      cnt_nxt = 4'h0;
    end else if (busy_r) begin
      cnt_nxt = cnt_r + 4'h1;
      if (cnt_r == 4'(SCR_CONV_CYCLES - 1)) begin
        busy_nxt = 1'b0;
        ready_nxt = 1'b1;
      end
    end
    if (busy_r && cond) begin
      iflag_nxt = 1'b1;
    end
    held_nxt = chan_r[SCR_B_LATCH] ? (held_r || cond) : 1'b0;
    pin_act_nxt = cond || held_r;
    drv_nxt = chan_nxt[SCR_B_PPOL] ? pin_act_nxt : !pin_act_nxt;
    bw_nxt = ((ctrl_nxt[3:1] == SCR_PM_LP3) || (ctrl_nxt[3:1] == SCR_PM_LP4))
             ? filt_nxt[10:8] : filt_nxt[6:4];
    unl_nxt = (key_nxt == SCR_UNLOCK_VALUE);
  end

  always_comb begin
    rdata_nxt = SCR_RST_ZERO;
    if (lnk.rd) begin
      unique case (lnk.addr)
        SCR_OFS_CTRL: rdata_nxt = ctrl_r | {3'h0, busy_r, iflag_r, ready_r, 10'h000};
        SCR_OFS_THR: rdata_nxt = thr_r;
        SCR_OFS_CHAN: rdata_nxt = chan_r;
        SCR_OFS_FILT: rdata_nxt = filt_r;
        SCR_OFS_RSVD: rdata_nxt = rsvd_r;
        SCR_OFS_KEY: rdata_nxt = key_r;
        default: rdata_nxt = SCR_RST_ZERO;
      endcase
    end
    // Identity rows are registered from fixed content, with the error flags in bits 31:30.
    row_nxt = row_sel ? {6'h00, SCR_FACTORY_TAG, 22'h000000}
                      : {6'h00, SCR_FACTORY_TAG, SCR_DIE_Y_POSITION, 14'h0000};
    row_nxt[31:30] = row_ecc_err;
    ecc_nxt = row_ecc_err;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= SCR_RST_ZERO;
      thr_r <= SCR_RST_ZERO;
      chan_r <= SCR_RST_ZERO;
      filt_r <= SCR_RST_ZERO;
      rsvd_r <= SCR_RST_ZERO;
      key_r <= SCR_RST_ZERO;
      rdata_r <= SCR_RST_ZERO;
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      iflag_r <= 1'b0;
      ready_r <= 1'b0;
      pin_act_r <= 1'b0;
      held_r <= 1'b0;
      drv_r <= 1'b1;
      bw_r <= 3'h0;
      unl_r <= 1'b0;
      row_r <= 32'h00000000;
      ecc_r <= 2'h0;
    end else begin
      ctrl_r <= ctrl_nxt;
      thr_r <= thr_nxt;
      chan_r <= chan_nxt;
      filt_r <= filt_nxt;
      rsvd_r <= rsvd_nxt;
      key_r <= key_nxt;
      rdata_r <= rdata_nxt;
      cnt_r <= cnt_nxt;
      busy_r <= busy_nxt;
      iflag_r <= iflag_nxt;
      ready_r <= ready_nxt;
      pin_act_r <= pin_act_nxt;
      held_r <= held_nxt;
      drv_r <= drv_nxt;
      bw_r <= bw_nxt;
      unl_r <= unl_nxt;
      row_r <= row_nxt;
      ecc_r <= ecc_nxt;
    end
  end

  // ==========================================================================
  // Outputs, all from flip-flops
  assign lnk.rdata = rdata_r;
  assign lnk.row_data = row_r;
  assign lnk.ecc_single = ecc_r[0];
  assign lnk.ecc_multi = ecc_r[1];
  // Pin drives only while the threshold condition holds or the latch bit holds it, so the host may start samples otherwise.
  assign lnk.pin_drv = drv_r;
  assign lnk.pin_oe = pin_act_r;
  assign chan_off = chan_r[13:11];
  assign chan_invert = chan_r[10:8];
  assign bandwidth_sel = bw_r;
  assign sleep_interval = ctrl_r[6:4];
  assign power_mode = ctrl_r[3:1];
  assign angle_cfg = filt_r[3:0];
  assign memory_unlocked = unl_r;
  assign converting = busy_r;
endmodule
`default_nettype wire

/* logic/scr_host.sv */
// Purpose: Host end that issues register accesses to the sensor bank.
// Assumes: Software drives a plain command port; one access at a time.
// Notes: Reserved register is written only with zero by this end.
`timescale 1ns/100ps
`default_nettype none
module scr_host
  import scr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Software command port
  input wire logic [3:0] sw_addr,
  input wire logic [15:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [15:0] sw_rdata,
  // Register link
  scr_link_if.host lnk
);
  import scr_pkg::*;
  scr_hstate_t st_r, st_nxt;
  logic [7:0] addr_r, addr_nxt, laddr_r, laddr_nxt;
  logic [15:0] wd_r, wd_nxt, res_r, res_nxt, swr_r, swr_nxt, lwd_r, lwd_nxt;
  logic wr_r, wr_nxt, rd_r, rd_nxt, done_r, done_nxt, blk_r, blk_nxt, pin_r, pin_nxt;

  always_comb begin
    st_nxt = st_r;
    addr_nxt = addr_r;
    wd_nxt = wd_r;
    res_nxt = res_r;
    laddr_nxt = laddr_r;
    lwd_nxt = lwd_r;
    wr_nxt = 1'b0;
    rd_nxt = 1'b0;
    done_nxt = done_r;
    blk_nxt = blk_r;
    pin_nxt = pin_r;
    swr_nxt = SCR_RST_ZERO;
    if (sw_wr) begin
      unique case (sw_addr)
        SCR_HOFS_ADDR: addr_nxt = sw_wdata[7:0];
        SCR_HOFS_WDATA: wd_nxt = sw_wdata;
        SCR_HOFS_STAT: pin_nxt = sw_wdata[0];
        default: ;
      endcase
    end
    if (sw_rd) begin
      unique case (sw_addr)
        SCR_HOFS_ADDR: swr_nxt = {8'h00, addr_r};
        SCR_HOFS_WDATA: swr_nxt = wd_r;
        SCR_HOFS_RDATA: swr_nxt = res_r;
        SCR_HOFS_STAT: swr_nxt = {12'h000, blk_r, st_r != SCR_H_IDLE, done_r, pin_r};
        default: swr_nxt = SCR_RST_ZERO;
      endcase
    end
    unique case (st_r)
      SCR_H_IDLE: begin
        if (sw_wr && sw_addr == SCR_HOFS_CMD) begin
          done_nxt = 1'b0;
          laddr_nxt = addr_r;
          lwd_nxt = wd_r;
          if (sw_wdata[1]) begin
            st_nxt = SCR_H_RD;
          end else if (addr_r == SCR_OFS_RSVD && wd_r != SCR_RST_ZERO) begin
            blk_nxt = 1'b1;
            done_nxt = 1'b1;
          end else begin
            blk_nxt = 1'b0;
            st_nxt = SCR_H_WR;
          end
        end
      end
      SCR_H_WR: begin
        wr_nxt = 1'b1;
        done_nxt = 1'b1;
        st_nxt = SCR_H_IDLE;
      end
      SCR_H_RD: begin
        rd_nxt = 1'b1;
        st_nxt = SCR_H_WAIT;
      end
      SCR_H_WAIT: begin
        if (!rd_r) begin
          res_nxt = lnk.rdata;
          done_nxt = 1'b1;
          st_nxt = SCR_H_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= SCR_H_IDLE;
      addr_r <= 8'h00;
      laddr_r <= 8'h00;
      wd_r <= SCR_RST_ZERO;
      lwd_r <= SCR_RST_ZERO;
      res_r <= SCR_RST_ZERO;
      swr_r <= SCR_RST_ZERO;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      done_r <= 1'b0;
      blk_r <= 1'b0;
      pin_r <= 1'b1;
    end else begin
      st_r <= st_nxt;
      addr_r <= addr_nxt;
      laddr_r <= laddr_nxt;
      wd_r <= wd_nxt;
      lwd_r <= lwd_nxt;
      res_r <= res_nxt;
      swr_r <= swr_nxt;
      wr_r <= wr_nxt;
      rd_r <= rd_nxt;
      done_r <= done_nxt;
      blk_r <= blk_nxt;
      pin_r <= pin_nxt;
    end
  end

  assign lnk.addr = laddr_r;
  assign lnk.wdata = lwd_r;
  assign lnk.wr = wr_r;
  assign lnk.rd = rd_r;
  assign lnk.pin_host = pin_r;
  assign sw_rdata = swr_r;
endmodule
`default_nettype wire

/* dv/scr_chk.sv */
// Purpose: Link checks between the host and device ends of the register bank.
// Assumes: One clock, reset asynchronous and active low.
// Notes: Shadows copy what the host writes, so read data can be judged.
`timescale 1ns/100ps
`default_nettype none
module scr_chk
  import scr_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Link
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [15:0] rdata,
  input wire logic pin_drv,
  input wire logic pin_oe
);
  import scr_pkg::*;
  // ==========================================================================
  // Shadows
  logic [15:0] thr_r, chan_r, key_r, thr_nxt, chan_nxt, key_nxt;
  always_comb begin
    thr_nxt = thr_r;
    chan_nxt = chan_r;
    key_nxt = key_r;
    if (wr && addr == SCR_OFS_THR) thr_nxt = wdata & SCR_MSK_THR;
    if (wr && addr == SCR_OFS_CHAN) chan_nxt = wdata & SCR_MSK_CHAN;
    if (wr && addr == SCR_OFS_KEY) key_nxt = wdata;
  end
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      thr_r <= 16'h0000;
      chan_r <= 16'h0000;
      key_r <= 16'h0000;
    end else begin
      thr_r <= thr_nxt;
      chan_r <= chan_nxt;
      key_r <= key_nxt;
    end
  end
  // ==========================================================================
  // Properties
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_thr;
    rd && addr == SCR_OFS_THR |=> rdata == thr_r;
  endproperty
  a_thr: assert property (p_thr) else $error("threshold readback wrong");
  property p_chan;
    rd && addr == SCR_OFS_CHAN |=> rdata == chan_r;
  endproperty
  a_chan: assert property (p_chan) else $error("channel setup readback wrong");
  property p_key;
    rd && addr == SCR_OFS_KEY |=> rdata == key_r;
  endproperty
  a_key: assert property (p_key) else $error("key readback wrong");
  property p_filt;
    rd && addr == SCR_OFS_FILT |=> (rdata & ~SCR_MSK_FILT) == 16'h0000;
  endproperty
  a_filt: assert property (p_filt) else $error("filter zero bits set");
  property p_ctrl;
    rd && addr == SCR_OFS_CTRL |=> (rdata & 16'he381) == 16'h0000;
  endproperty
  a_ctrl: assert property (p_ctrl) else $error("control zero bits set");
  property p_unmap;
    rd && addr > SCR_OFS_KEY |=> rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rsvd;
    wr && addr == SCR_OFS_RSVD |-> wdata == 16'h0000;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved written nonzero");
  property p_pol;
    pin_oe && $stable(chan_r) |-> pin_drv == chan_r[SCR_B_PPOL];
  endproperty
  a_pol: assert property (p_pol) else $error("pin level against polarity");
  c_iflag: cover property (rd && addr == SCR_OFS_CTRL ##1 rdata[SCR_B_IFLAG]);
  c_pin: cover property ($rose(pin_oe));
  c_unmap: cover property (rd && addr > SCR_OFS_KEY);
endmodule
`default_nettype wire

/* dv/testbench.sv */
// Purpose: Self-checking bench driving the host command port.
// Assumes: Host command timing as handed over; one access at a time.
// Notes: Pin parks inactive so the device stays in standby between tests.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import scr_pkg::*;
  // ==========================================================================
  // Signals
  logic clk_sys, rst_n, sw_wr, sw_rd, row_sel, memory_unlocked, converting;
  logic [3:0] sw_addr, angle_cfg;
  logic [15:0] sw_wdata, sw_rdata, v;
  logic [11:0] sense_value [16];
  logic [1:0] row_ecc_err;
  logic [2:0] chan_off, chan_invert, bandwidth_sel, sleep_interval, power_mode;
  int err_count, checks, cyc;
  logic [7:0] ra [5] = '{SCR_OFS_CTRL, SCR_OFS_THR, SCR_OFS_CHAN, SCR_OFS_FILT, SCR_OFS_KEY};
  logic [15:0] rw [5] = '{16'h0e7f, 16'hffff, 16'hfffe, 16'hffff, SCR_UNLOCK_VALUE};
  logic [15:0] rx [5] = '{16'h007e, 16'h0fff, 16'h3f7e, 16'h077f, SCR_UNLOCK_VALUE};
  scr_link_if i_scr_link_if();
  scr_host i_scr_host(.clk_sys(clk_sys), .rst_n(rst_n), .sw_addr(sw_addr),
    .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata),
    .lnk(i_scr_link_if));
  scr_device i_scr_device(.clk_sys(clk_sys), .rst_n(rst_n), .lnk(i_scr_link_if),
    .sense_value(sense_value), .row_sel(row_sel), .row_ecc_err(row_ecc_err),
    .chan_off(chan_off), .chan_invert(chan_invert), .bandwidth_sel(bandwidth_sel),
    .sleep_interval(sleep_interval), .power_mode(power_mode), .angle_cfg(angle_cfg),
    .memory_unlocked(memory_unlocked), .converting(converting));
  scr_chk i_scr_chk(.clk_sys(clk_sys), .rst_n(rst_n), .addr(i_scr_link_if.addr),
    .wdata(i_scr_link_if.wdata), .wr(i_scr_link_if.wr), .rd(i_scr_link_if.rd),
    .rdata(i_scr_link_if.rdata), .pin_drv(i_scr_link_if.pin_drv),
    .pin_oe(i_scr_link_if.pin_oe));
  // ==========================================================================
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  task automatic sw(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_wdata <= d;
    sw_wr <= 1'b1;
    @(posedge clk_sys);
    sw_wr <= 1'b0;
  endtask
  task automatic swr(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clk_sys);
    sw_rd <= 1'b0;
    #1 d = sw_rdata;
  endtask
  task automatic dev_wr(input logic [7:0] a, input logic [15:0] d);
    sw(SCR_HOFS_ADDR, {8'h00, a});
    sw(SCR_HOFS_WDATA, d);
    sw(SCR_HOFS_CMD, 16'h0000);
    repeat (6) @(posedge clk_sys);
    #1;
  endtask
  task automatic dev_rd(input logic [7:0] a, output logic [15:0] d);
    sw(SCR_HOFS_ADDR, {8'h00, a});
    sw(SCR_HOFS_CMD, 16'h0002);
    repeat (6) @(posedge clk_sys);
    swr(SCR_HOFS_RDATA, d);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================================================
  // Clock, timeout and sequence
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 5000) begin
      err_count++;
      give_verdict();
    end
  end
  initial begin
    rst_n = 1'b0;
    {sw_addr, sw_wdata, sw_wr, sw_rd, row_sel} = '0;
    row_ecc_err = 2'b01;
    foreach (sense_value[i]) sense_value[i] = 12'h100;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    sw(SCR_HOFS_STAT, 16'h0001);
    chk({15'h0000, converting}, 16'h0000);
    repeat (20) @(posedge clk_sys);
    dev_wr(SCR_OFS_CTRL, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      dev_rd(ra[i], v);
      chk(v, 16'h0000);
    end
    dev_wr(8'h40, 16'hffff);
    dev_rd(8'h40, v);
    chk(v, 16'h0000);
    dev_wr(SCR_OFS_RSVD, 16'h0001);
    swr(SCR_HOFS_STAT, v);
    chk({15'h0000, v[3]}, 16'h0001);
    dev_rd(SCR_OFS_RSVD, v);
    chk(v, 16'h0000);
    chk({4'h0, i_scr_link_if.row_data[25:14]}, {4'h0, SCR_FACTORY_TAG, SCR_DIE_Y_POSITION});
    chk({14'h0000, i_scr_link_if.ecc_multi, i_scr_link_if.ecc_single}, 16'h0001);
    @(posedge clk_sys);
    row_sel <= 1'b1;
    row_ecc_err <= 2'b10;
    repeat (2) @(posedge clk_sys);
    #1;
    chk({12'h000, i_scr_link_if.row_data[25:22]}, {12'h000, SCR_FACTORY_TAG});
    chk({14'h0000, i_scr_link_if.row_data[31:30]}, 16'h0002);
    chk({14'h0000, i_scr_link_if.ecc_multi, i_scr_link_if.ecc_single}, 16'h0002);
    $display("test reset and identity done");
    chk({15'h0000, converting}, 16'h0000);
    sw(SCR_HOFS_STAT, 16'h0000);
    for (int i = 0; i < 20 && converting !== 1'b1; i++) @(posedge clk_sys);
    chk({15'h0000, converting}, 16'h0001);
    sw(SCR_HOFS_STAT, 16'h0001);
    repeat (20) @(posedge clk_sys);
    dev_wr(SCR_OFS_CTRL, 16'h0000);
    $display("test standby done");
    for (int i = 0; i < 5; i++) begin
      dev_wr(ra[i], rw[i]);
      dev_rd(ra[i], v);
      chk(v, rx[i]);
    end
    chk({chan_off, chan_invert, sleep_interval, power_mode, angle_cfg}, 16'hffff);
    chk({15'h0000, memory_unlocked}, 16'h0001);
    dev_wr(SCR_OFS_FILT, 16'h0350);
    for (int m = 0; m < 5; m++) begin
      dev_wr(SCR_OFS_CTRL, {12'h000, m[2:0], 1'b0});
      chk({13'h0000, bandwidth_sel}, (m == 3 || m == 4) ? 16'h0003 : 16'h0005);
    end
    $display("test register rows done");
    dev_wr(SCR_OFS_CTRL, 16'h1000);
    chk({15'h0000, converting}, 16'h0001);
    repeat (10) @(posedge clk_sys);
    dev_rd(SCR_OFS_CTRL, v);
    chk(v, 16'h0400);
    dev_wr(SCR_OFS_CTRL, 16'h1400);
    chk({15'h0000, converting}, 16'h0000);
    dev_wr(SCR_OFS_CTRL, 16'h0000);
    dev_rd(SCR_OFS_CTRL, v);
    chk(v, 16'h0000);
    $display("test conversion done");
    dev_wr(SCR_OFS_CHAN, 16'h0002);
    dev_wr(SCR_OFS_CTRL, 16'h1000);
    chk({14'h0000, i_scr_link_if.pin_oe, i_scr_link_if.pin_drv}, 16'h0002);
    repeat (10) @(posedge clk_sys);
    dev_wr(SCR_OFS_THR, 16'h0000);
    chk({15'h0000, i_scr_link_if.pin_oe}, 16'h0001);
    dev_rd(SCR_OFS_CTRL, v);
    chk(v, 16'h0c00);
    dev_wr(SCR_OFS_CHAN, 16'h0000);
    chk({15'h0000, i_scr_link_if.pin_oe}, 16'h0000);
    dev_wr(SCR_OFS_CTRL, 16'h0400);
    dev_rd(SCR_OFS_CTRL, v);
    chk(v, 16'h0400);
    dev_wr(SCR_OFS_CHAN, 16'h0005);
    dev_wr(SCR_OFS_CTRL, 16'h0000);
    for (int i = 0; i < 20 && converting !== 1'b1; i++) @(posedge clk_sys);
    chk({15'h0000, converting}, 16'h0001);
    repeat (2) @(posedge clk_sys);
    chk({14'h0000, i_scr_link_if.pin_oe, i_scr_link_if.pin_drv}, 16'h0003);
    dev_wr(SCR_OFS_THR, 16'h0fff);
    chk({15'h0000, i_scr_link_if.pin_oe}, 16'h0000);
    $display("test interrupt pin done");
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk({13'h0000, converting, memory_unlocked, i_scr_link_if.pin_oe}, 16'h0000);
    dev_rd(SCR_OFS_KEY, v);
    chk(v, 16'h0000);
    dev_rd(SCR_OFS_CTRL, v);
    chk(v, 16'h0000);
    $display("test mid-run reset done");
    give_verdict();
  end
endmodule
`default_nettype wire
